// ==== core/ubrg_pkg.sv ====
// package of constants for the serial transceiver baud rate generator
// assumes one master clock domain; no software bus, config arrives on ports
//
// Summary of operation
// - one bit clock to receiver and transmitter
// - source is master, master/8, or pin
// - sixteen-bit divider ratio from clock_divisor
// - divisor zero produces no clock
// - divisor one bypasses the divider
// - sampling clock, then divide by 8/16
// - fastest bit rate is master over 8
// - stopped clock resumes from held state
// - configuration accepted while clock disabled
// - absent modem pins have no effect
package ubrg_pkg;
  // divisor width
  localparam int unsigned DIV_W        = 16;
  // fixed product divider on the master clock
  localparam logic [3:0]  PRESCALE_DIV = 4'h8;
  // oversampling counts
  localparam logic [3:0]  OVS_16_LAST  = 4'hf;
  localparam logic [3:0]  OVS_8_LAST   = 4'h7;
  // reset values
  localparam logic [15:0] DIVISOR_RST  = 16'h0000;
  localparam logic [1:0]  SRC_RST      = 2'h0;

  // clock source selection codes
  typedef enum logic [1:0] {
    UBRG_SRC_MAST = 2'b00,
    UBRG_SRC_DIV  = 2'b01,
    UBRG_SRC_RSV  = 2'b10,
    UBRG_SRC_PIN  = 2'b11
  } ubrg_src_e;
endpackage : ubrg_pkg

// ==== core/ubrg_pin_edge.sv ====
// rising edge detector for the external serial clock pin
// assumes the pin is synchronous to clk and slower than clk/4.5
`timescale 1ns/10ps
`default_nettype none
module ubrg_pin_edge (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ce,
  // pin in, pulse out
  input  wire logic pin,
  output logic      rise
);
  import ubrg_pkg::*;

  logic pin_q; // previous pin level

  // remember last level; frozen with clock enable
  always_ff @(posedge clk) begin
    if (!nrst) begin
      // start high: a pin left high across reset gives no false edge
      pin_q <= 1'b1;
    end else if (ce) begin
      pin_q <= pin;
    end
  end

  // phases longer than a period, so each edge seen
  assign rise = ce & pin & ~pin_q;
endmodule : ubrg_pin_edge
`default_nettype wire

// ==== core/ubrg_top.sv ====
// baud rate generator: source select, divisor, oversampling divide
// assumes config ports are held by the owning register file
`timescale 1ns/10ps
`default_nettype none
module ubrg_top (
  // clock, reset, enable
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  // configuration
  input  wire logic [1:0] clock_source_select,
  input  wire logic [15:0] clock_divisor,
  input  wire logic       oversampling_select,
  // external clock pin
  input  wire logic       serial_clock_pin,
  // outputs
  output logic            sample_tick,
  output logic            bit_tick
);
  import ubrg_pkg::*;

  ////////////////////////////////////////////////////////////////
  // source enable

  logic [3:0]  pre_q;    // fixed prescaler counter
  logic        pin_rise; // pin edge pulse
  logic        src_en;   // selected source tick

  // no modem pins here, nothing to gate
  ubrg_pin_edge u_edge (
    .clk  (clk),
    .nrst (nrst),
    .ce   (ce),
    .pin  (serial_clock_pin),
    .rise (pin_rise)
  );

  // fixed divide-by-8 prescaler
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pre_q <= 4'h0;
    end else if (ce) begin
      // ce low freezes state, resume later
      pre_q <= (pre_q == PRESCALE_DIV - 4'h1) ? 4'h0 : pre_q + 4'h1;
    end
  end

  always_comb begin
    case (ubrg_src_e'(clock_source_select))
      UBRG_SRC_MAST: src_en = ce;
      UBRG_SRC_DIV: src_en = ce & (pre_q == PRESCALE_DIV - 4'h1);
      UBRG_SRC_PIN: src_en = pin_rise;
      default:      src_en = 1'b0; // reserved code: no clock
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // divisor counter

  logic [15:0] div_q;  // counts source ticks
  logic        div_en; // divided tick

  always_ff @(posedge clk) begin
    if (!nrst) begin
      div_q <= DIVISOR_RST;
    end else if (ce && src_en) begin
      if (div_q >= clock_divisor - 16'h1) begin
        div_q <= 16'h0000;
      end else begin
        div_q <= div_q + 16'h1;
      end
    end
  end

  // zero stops; one passes source straight
  always_comb begin
    if (clock_divisor == 16'h0000) begin
      div_en = 1'b0;
    end else if (clock_divisor == 16'h0001) begin
      div_en = src_en;
    end else begin
      div_en = src_en & (div_q >= clock_divisor - 16'h1);
    end
  end

  ////////////////////////////////////////////////////////////////
  // oversampling divide

  logic [3:0] ovs_q;  // sample count within a bit
  logic [3:0] ovs_last;

  assign ovs_last = oversampling_select ? OVS_8_LAST : OVS_16_LAST;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ovs_q <= 4'h0;
    end else if (ce && div_en) begin
      ovs_q <= (ovs_q >= ovs_last) ? 4'h0 : ovs_q + 4'h1;
    end
  end

  // registered ticks; fastest bit tick is master/8
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sample_tick <= 1'b0;
      bit_tick    <= 1'b0;
    end else if (ce) begin
      sample_tick <= div_en;
      // one bit tick shared by rx and tx
      bit_tick    <= div_en & (ovs_q >= ovs_last);
    end else begin
      sample_tick <= 1'b0;
      bit_tick    <= 1'b0;
    end
  end
  // config are plain ports, writable anytime
endmodule : ubrg_top
`default_nettype wire

// ==== tb/ubrg_top_asserts.sv ====
// checker: tick relations seen at ubrg_top ports
`timescale 1ns/10ps
`default_nettype none
module ubrg_top_asserts (input wire logic clk, nrst, ce, oversampling_select, serial_clock_pin,
  sample_tick, bit_tick, input wire logic [1:0] clock_source_select,
  input wire logic [15:0] clock_divisor);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [3:0] n_q; // sample ticks since last bit tick
  always_ff @(posedge clk) n_q <= (!nrst || bit_tick) ? 4'h0 : n_q + 4'(sample_tick);
  AST_DIV0:
    assert property (clock_divisor == 0 && $stable(clock_divisor) |-> !sample_tick) else $error("div0");
  AST_BYPASS:
    assert property ($past(nrst) && ce && $past(ce) && clock_divisor == 1 && $stable(clock_divisor)
      && clock_source_select == 0 && $stable(clock_source_select) |-> sample_tick) else $error("bypass");
  AST_SRC_NONE:
    assert property (clock_source_select == 2 && $stable(clock_source_select) |-> !sample_tick)
      else $error("src2");
  AST_SRC_DIV:
    assert property (sample_tick && clock_source_select == 1 |=> !sample_tick) else $error("src1");
  AST_PAIR:
    assert property (bit_tick |-> sample_tick) else $error("pair");
  AST_RATIO:
    assert property (bit_tick |-> n_q == (oversampling_select ? 4'h7 : 4'hf)) else $error("ratio");
  AST_FREEZE:
    assert property (!ce && !$past(ce) |-> !sample_tick && !bit_tick) else $error("freeze");
  AST_PULSE:
    assert property (sample_tick && clock_divisor > 1 |=> !sample_tick) else $error("pulse");
endmodule : ubrg_top_asserts
bind ubrg_top ubrg_top_asserts chk (.clk, .nrst, .ce, .oversampling_select, .serial_clock_pin,
  .sample_tick, .bit_tick, .clock_source_select, .clock_divisor);
`default_nettype wire

// ==== tb/ubrg_pin_src.sv ====
// partner: external clock on the pin, stands still while run is low
`timescale 1ns/10ps
`default_nettype none
module ubrg_pin_src #(parameter int HALF = 3) (input wire logic clk, run, output logic pin);
  int c = 0;
  initial pin = 1'b0;
  // phases of 3 periods, 6 > 4.5
  // run is changed on the falling edge, so sample it on the rising one
  always @(posedge clk) if (run) begin
    c = (c == HALF - 1) ? 0 : c + 1;
    if (c == 0) pin <= ~pin;
  end
endmodule : ubrg_pin_src
`default_nettype wire

// ==== tb/usart_baud_rate_generator_test.sv ====
// bench: every source and ratio, tick counts against an integer model
`timescale 1ns/10ps
`default_nettype none
module usart_baud_rate_generator_test;
  logic clk = 0, nrst = 0, ce = 0, ovs = 0, pin, st, bt;
  logic [1:0] src = 0;
  logic [15:0] dv = 0;
  int mismatches = 0, n_checks = 0, cyc = 0, ns, nb, e;
  ubrg_top dut (.clk, .nrst, .ce, .clock_source_select(src), .clock_divisor(dv),
    .oversampling_select(ovs), .serial_clock_pin(pin), .sample_tick(st), .bit_tick(bt));
  ubrg_pin_src ext (.clk, .run(ce), .pin);
  initial forever #2.5 clk = ~clk;
  // model counters and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ns <= (nrst === 1'b1) ? ns + int'(st === 1'b1) : 0;
    nb <= (nrst === 1'b1) ? nb + int'(bt === 1'b1) : 0;
    if (cyc == 20000) begin mismatches++; finish_test; end
  end
  task automatic chk(int got, int exp); // one count slack for phase
    n_checks++;
    if (got > exp + 1 || got + 1 < exp) begin
      mismatches++; $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask : chk
  task finish_test;
    $display("checks %0d bad %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  initial begin
    void'($urandom(32'hdd0e));
    repeat (6) @(negedge clk);
    for (int s = 0; s < 4; s++) for (int o = 0; o < 2; o++) begin
      nrst = 0; src = 2'(s); ovs = o[0];
      dv = (s == 0) ? 16'(o) : 16'($urandom_range(4));
      @(negedge clk) nrst = 1; ce = 1;
      repeat (480) @(negedge clk);
      ce = 0; repeat (20) @(negedge clk); ce = 1;
      repeat (480) @(negedge clk);
      ce = 0; repeat (3) @(negedge clk);
      e = (s == 0) ? 960 : (s == 1) ? 120 : (s == 3) ? 160 : 0;
      e = dv ? e / int'(dv) : 0;
      chk(ns, e);
      chk(nb, e / (o ? 8 : 16));
    end
    finish_test;
  end
endmodule : usart_baud_rate_generator_test
`default_nettype wire
